// [core/dot_clock_params.svh]
`ifndef DOT_CLOCK_PARAMS_SVH
`define DOT_CLOCK_PARAMS_SVH

// Fixed upper twelve bits of the direct mode command, D15 down to D4.
`define DCS_CMD_PREFIX     12'hB0F
`define DCS_CMD_TAIL       2'h0
`define DCS_CMD_BITS       16
`define DCS_CODE_SET       2'h3
`define DCS_CODE_CLEAR     2'h0

// Clock period and settle interval around horizontal sync, in nanoseconds.
`define DCS_CLK_NS         50
`define DCS_PERIOD_A_FAST_NS 200
`define DCS_PERIOD_A_SLOW_NS 500
`define DCS_PERIOD_A_FAST_CYC ((`DCS_PERIOD_A_FAST_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
`define DCS_PERIOD_A_SLOW_CYC ((`DCS_PERIOD_A_SLOW_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)

// Dot clocks delivered after the settle interval, by horizontal size.
`define DCS_TAIL_SINGLE    4
`define DCS_TAIL_DOUBLE    8

`endif

// [core/dot_clock_pkg.sv]
package dot_clock_pkg;

  typedef enum logic {
    REQ_RAW,
    REQ_MODE
  } req_kind_t;

  typedef struct packed {
    req_kind_t   kind;
    logic [1:0]  code;
    logic [15:0] word;
  } cmd_req_t;

  typedef enum logic [2:0] {
    CLK_OFF,
    CLK_RUN,
    CLK_FALL_WAIT,
    CLK_TAIL,
    CLK_HALT,
    CLK_RISE_WAIT
  } clk_state_t;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_SHIFT,
    SH_END
  } sh_state_t;

endpackage

// [core/serial_cmd_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dot_clock_params.svh"

module serial_cmd_shifter
  import dot_clock_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Word to send
  input  wire logic        start,
  input  wire logic [15:0] word,
  output logic             done,
  // Serial pins
  output logic             ser_clk,
  output logic             ser_data,
  output logic             ser_cs_n
);

  sh_state_t   st_q, st_d;
  logic [15:0] sh_q, sh_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        ph_q, ph_d;
  logic        sclk_q, sclk_d;
  logic        data_q, data_d;
  logic        cs_n_q, cs_n_d;
  logic        done_q, done_d;

  // Bits leave least significant first; the device samples on the rising serial clock.
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    ph_d   = ph_q;
    sclk_d = sclk_q;
    data_d = data_q;
    cs_n_d = cs_n_q;
    done_d = 1'b0;
    case (st_q)
      SH_IDLE: begin
        sclk_d = 1'b1;
        cs_n_d = 1'b1;
        if (start) begin
          sh_d   = word;
          cnt_d  = 4'h0;
          ph_d   = 1'b0;
          cs_n_d = 1'b0;
          st_d   = SH_SHIFT;
        end
      end
      SH_SHIFT: begin
        ph_d = ~ph_q;
        if (!ph_q) begin
          sclk_d = 1'b0;
          data_d = sh_q[0];
        end else begin
          sclk_d = 1'b1;
          sh_d   = {1'b0, sh_q[15:1]};
          cnt_d  = cnt_q + 4'h1;
          if (cnt_q == 4'(`DCS_CMD_BITS - 1)) begin
            st_d = SH_END;
          end
        end
      end
      SH_END: begin
        cs_n_d = 1'b1;
        done_d = 1'b1;
        st_d   = SH_IDLE;
      end
      default: st_d = SH_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= SH_IDLE;
      sh_q   <= 16'h0000;
      cnt_q  <= 4'h0;
      ph_q   <= 1'b0;
      sclk_q <= 1'b1;
      data_q <= 1'b0;
      cs_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      ph_q   <= ph_d;
      sclk_q <= sclk_d;
      data_q <= data_d;
      cs_n_q <= cs_n_d;
      done_q <= done_d;
    end
  end

  assign done     = done_q;
  assign ser_clk  = sclk_q;
  assign ser_data = data_q;
  assign ser_cs_n = cs_n_q;

  AST_FRAME_SELECT: assert property (@(posedge clk) disable iff (rst) // RL2
    $fell(cs_n_q) |-> !cs_n_q [*8] ##26 $rose(cs_n_q))
    else $error("Command frame does not span sixteen serial clocks.");

endmodule
`default_nettype wire

// [core/dot_clock_source_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dot_clock_params.svh"

// Behaviour
// RL1: Direct mode changes only by command, NTSC.
// RL2: Mode word is prefix, two-bit code, zeros.
// RL3: Code 11 enters direct subcarrier mode.
// RL4: Code 00 returns to normal oscillation.
// RL5: Never send codes 01 or 10.
// RL6: Direct mode clocks solely from subcarrier.
// RL7: Otherwise device runs normal oscillation.
// RL8: Crystal oscillation off before direct mode.
// RL9: Video standard must be NTSC too.
// RL10: Direct mode colours exclude green.
// RL11: External dot clock halted during sync.
// RL12: After sync fall, delay plus clocks, stop.
// RL13: Extra clocks: four single, eight double.
// RL14: Delay about 200 or 500 ns.
// RL15: Clock still halted at sync rise.
// RL16: Resume only after delay past rise.
// RL17: Dot clock phase fixed to sync.
// RL18: Memory writes wait for clock restart.
module dot_clock_source_control
  import dot_clock_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // Command requests
  input  wire logic     req_valid,
  input  wire cmd_req_t req,
  output logic          req_ready,
  output logic          cmd_done,
  output logic          cmd_refused,
  // Settings known to the user
  input  wire logic     std_ntsc,
  input  wire logic     osc_off,
  input  wire logic     ext_clk_en,
  input  wire logic     slow_variant,
  input  wire logic     char_double,
  // Device pins
  input  wire logic     hsync_n_pin,
  output logic          dot_clk_pin,
  output logic          ser_clk_pin,
  output logic          ser_data_pin,
  output logic          ser_cs_n_pin,
  // Status
  output logic          direct_mode,
  output logic          green_allowed
);

  function automatic logic [3:0] period_a(input logic slow);
    period_a = slow ? 4'(`DCS_PERIOD_A_SLOW_CYC) : 4'(`DCS_PERIOD_A_FAST_CYC);
  endfunction

  function automatic logic [3:0] tail_len(input logic dbl);
    tail_len = dbl ? 4'(`DCS_TAIL_DOUBLE) : 4'(`DCS_TAIL_SINGLE);
  endfunction

  // Command group.
  logic        busy_q, busy_d;
  logic        ready_q, ready_d;
  logic        start_q, start_d;
  logic [15:0] word_q, word_d;
  logic        pend_mode_q, pend_mode_d;
  logic [1:0]  pend_code_q, pend_code_d;
  logic        done_q, done_d;
  logic        refused_q, refused_d;
  logic        direct_q, direct_d;
  logic        green_q, green_d;
  logic        sh_done;
  logic        take;
  logic        code_ok;

  assign take    = req_valid && ready_q;
  assign code_ok = (req.code == `DCS_CODE_SET) || (req.code == `DCS_CODE_CLEAR); // RL5

  always_comb begin
    busy_d      = busy_q;
    start_d     = 1'b0;
    word_d      = word_q;
    pend_mode_d = pend_mode_q;
    pend_code_d = pend_code_q;
    done_d      = 1'b0;
    refused_d   = 1'b0;
    direct_d    = direct_q;
    if (take) begin
      if (req.kind == REQ_MODE) begin
        // A set also needs the oscillator off; both directions need NTSC selected.
        if (!code_ok || !std_ntsc || (req.code == `DCS_CODE_SET && !osc_off)) begin // RL1 RL8 RL9
          refused_d = 1'b1;
        end else begin
          word_d      = {`DCS_CMD_PREFIX, req.code, `DCS_CMD_TAIL}; // RL2
          pend_mode_d = 1'b1;
          pend_code_d = req.code;
          start_d     = 1'b1;
          busy_d      = 1'b1;
        end
      end else begin
        word_d      = req.word;
        pend_mode_d = 1'b0;
        start_d     = 1'b1;
        busy_d      = 1'b1;
      end
    end
    if (sh_done) begin
      busy_d = 1'b0;
      done_d = 1'b1;
      if (pend_mode_q) begin
        direct_d = (pend_code_q == `DCS_CODE_SET); // RL3 RL4 RL6 RL7
      end
    end
    ready_d = !busy_d && !refused_d;
    green_d = !direct_d; // RL10
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q      <= 1'b0;
      ready_q     <= 1'b0;
      start_q     <= 1'b0;
      word_q      <= 16'h0000;
      pend_mode_q <= 1'b0;
      pend_code_q <= 2'h0;
      done_q      <= 1'b0;
      refused_q   <= 1'b0;
      direct_q    <= 1'b0;
      green_q     <= 1'b1;
    end else begin
      busy_q      <= busy_d;
      ready_q     <= ready_d;
      start_q     <= start_d;
      word_q      <= word_d;
      pend_mode_q <= pend_mode_d;
      pend_code_q <= pend_code_d;
      done_q      <= done_d;
      refused_q   <= refused_d;
      direct_q    <= direct_d;
      green_q     <= green_d;
    end
  end

  serial_cmd_shifter u_shifter (
    .clk      (clk),
    .rst      (rst),
    .start    (start_q),
    .word     (word_q),
    .done     (sh_done),
    .ser_clk  (ser_clk_pin),
    .ser_data (ser_data_pin),
    .ser_cs_n (ser_cs_n_pin)
  );

  // Sync pin capture; the third stage only serves the edge detector.
  logic hs_s1_q, hs_s2_q, hs_s3_q;
  logic hs_fall, hs_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_s1_q <= 1'b1;
      hs_s2_q <= 1'b1;
      hs_s3_q <= 1'b1;
    end else begin
      hs_s1_q <= hsync_n_pin;
      hs_s2_q <= hs_s1_q;
      hs_s3_q <= hs_s2_q;
    end
  end

  assign hs_fall = hs_s3_q && !hs_s2_q;
  assign hs_rise = !hs_s3_q && hs_s2_q;

  // Dot clock group: half the system clock, gated around each sync pulse.
  clk_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic       dclk_q, dclk_d;
  logic [3:0] tail_seen_q, tail_seen_d;

  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    dclk_d      = 1'b0;
    tail_seen_d = 4'h0;
    case (st_q)
      CLK_OFF: begin
        // Starting from a halt keeps the first edge tied to a sync rise.
        if (ext_clk_en) begin
          st_d = CLK_HALT;
        end
      end
      CLK_RUN: begin
        dclk_d = ~dclk_q;
        if (hs_fall) begin
          cnt_d = period_a(slow_variant) - 4'h1; // RL14
          st_d  = CLK_FALL_WAIT;
        end
      end
      CLK_FALL_WAIT: begin
        dclk_d = ~dclk_q;
        cnt_d  = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          st_d = CLK_TAIL;
        end
      end
      CLK_TAIL: begin
        // Counting rising edges keeps the tail exact whatever phase the clock entered with.
        dclk_d      = ~dclk_q;
        tail_seen_d = tail_seen_q + (dclk_q ? 4'h0 : 4'h1);
        if (dclk_q && tail_seen_q == tail_len(char_double)) begin // RL13
          dclk_d = 1'b0; // RL12
          st_d   = CLK_HALT;
        end
      end
      CLK_HALT: begin
        if (hs_rise) begin // RL11 RL15
          cnt_d = period_a(slow_variant) - 4'h1;
          st_d  = CLK_RISE_WAIT;
        end
      end
      CLK_RISE_WAIT: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          st_d = CLK_RUN; // RL16 RL17 RL18
        end
      end
      default: st_d = CLK_OFF;
    endcase
    if (!ext_clk_en) begin
      st_d   = CLK_OFF;
      dclk_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q        <= CLK_OFF;
      cnt_q       <= 4'h0;
      dclk_q      <= 1'b0;
      tail_seen_q <= 4'h0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      dclk_q      <= dclk_d;
      tail_seen_q <= tail_seen_d;
    end
  end

  assign req_ready     = ready_q;
  assign cmd_done      = done_q;
  assign cmd_refused   = refused_q;
  assign direct_mode   = direct_q;
  assign green_allowed = green_q;
  assign dot_clk_pin   = dclk_q;

  // Rises made while settling and in the tail, counted apart from the tail counter.
  logic [4:0] fall_rises_q, fall_rises_d;

  always_comb begin
    fall_rises_d = fall_rises_q;
    if (st_q == CLK_RUN) begin
      fall_rises_d = 5'h00;
    end else if ((st_q == CLK_FALL_WAIT || st_q == CLK_TAIL) && dclk_d && !dclk_q) begin
      fall_rises_d = fall_rises_q + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fall_rises_q <= 5'h00;
    end else begin
      fall_rises_q <= fall_rises_d;
    end
  end

  default clocking dcs_cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MODE_WORD: assert property ((start_q && pend_mode_q) |-> // RL2
    (word_q[15:4] == `DCS_CMD_PREFIX) && (word_q[1:0] == `DCS_CMD_TAIL))
    else $error("Mode command word malformed.");
  AST_NO_BAD_CODE: assert property ((start_q && pend_mode_q) |-> // RL5
    (word_q[3] == word_q[2]))
    else $error("Prohibited mode code sent.");
  AST_SET_GATED: assert property ((take && req.kind == REQ_MODE && // RL8
    (!std_ntsc || (req.code == `DCS_CODE_SET && !osc_off))) |=> cmd_refused && !start_q)
    else $error("Mode command sent without its preconditions.");
  AST_MODE_APPLY: assert property ((sh_done && pend_mode_q) |=> // RL3
    (direct_mode == (pend_code_q == `DCS_CODE_SET)) && !green_allowed == direct_mode)
    else $error("Direct mode flag does not follow the sent code.");
  AST_MODE_STEADY: assert property (!(sh_done && pend_mode_q) |=> $stable(direct_mode)) // RL1
    else $error("Direct mode changed without a command.");
  AST_FALL_DELAY: assert property ((st_q == CLK_RUN && hs_fall && ext_clk_en && // RL14
    !slow_variant) |=> (st_q == CLK_FALL_WAIT) [*4] ##1 (st_q == CLK_TAIL))
    else $error("Settle interval after sync fall is wrong.");
  AST_TAIL_COUNT: assert property ((st_q == CLK_TAIL && st_d == CLK_HALT) |-> // RL13
    fall_rises_q == 5'(period_a(slow_variant) >> 1) + 5'(tail_len(char_double)))
    else $error("Wrong number of dot clocks before stop.");
  AST_HALT_LOW: assert property ((st_q == CLK_HALT) |-> !dot_clk_pin) // RL11
    else $error("Dot clock toggles during sync.");
  AST_RISE_HALTED: assert property ((st_q == CLK_HALT && hs_rise && ext_clk_en) |=> // RL16
    !dot_clk_pin [*5])
    else $error("Dot clock resumed before the settle interval.");
  AST_RESUME: assert property ((st_q == CLK_RISE_WAIT && cnt_q == 4'h0 && ext_clk_en) |=> // RL17
    (st_q == CLK_RUN) ##1 dot_clk_pin)
    else $error("Dot clock did not restart in fixed phase.");

  COV_SET_DIRECT: cover property (sh_done && pend_mode_q && pend_code_q == `DCS_CODE_SET);
  COV_REFUSED: cover property (cmd_refused);
  COV_SYNC_CYCLE: cover property ((st_q == CLK_HALT) ##[1:200] (st_q == CLK_RUN));
  COV_DOUBLE_TAIL: cover property (st_q == CLK_TAIL && char_double);

endmodule
`default_nettype wire

// [verification/osd_device_model.sv]
`timescale 1ns/1ps
`default_nettype none

module osd_device_model (
  // Serial command pins
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_cs_n,
  input  wire logic        ntsc_sel,
  // Dot clock and sync
  input  wire logic        dot_clk,
  input  wire logic        hsync_n,
  // Observed device state
  output var logic  [15:0] last_word,
  output var logic         dev_direct,
  output var logic  [7:0]  frames,
  output var logic  [7:0]  dot_edges
);
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;

  initial begin
    sh_q       = 16'h0000;
    cnt_q      = 5'h00;
    last_word  = 16'h0000;
    dev_direct = 1'b0;
    frames     = 8'h00;
    dot_edges  = 8'h00;
  end

  always @(posedge ser_clk) begin
    if (!ser_cs_n) begin
      sh_q  = {ser_data, sh_q[15:1]};
      cnt_q = cnt_q + 5'h01;
    end
  end

  // A frame cut short is dropped, as the device would ignore a partial word.
  always @(posedge ser_cs_n) begin
    if (cnt_q == 5'h10) begin
      frames    = frames + 8'h01;
      last_word = sh_q;
      if (ntsc_sel && sh_q[15:4] == 12'hB0F && sh_q[1:0] == 2'h0) begin
        if (sh_q[3:2] == 2'h3) begin
          dev_direct = 1'b1;
        end else if (sh_q[3:2] == 2'h0) begin
          dev_direct = 1'b0;
        end
      end
    end
    cnt_q = 5'h00;
  end

  // Video memory writes in the device ride on these edges.
  always @(negedge hsync_n) dot_edges = 8'h00;
  always @(posedge dot_clk) dot_edges = dot_edges + 8'h01;

endmodule

`default_nettype wire

// [verification/dot_clock_source_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module dot_clock_source_control_bench;
  import dot_clock_pkg::*;

  logic clk, rst, req_valid, req_ready, cmd_done, cmd_refused;
  logic std_ntsc, osc_off, ext_clk_en, slow_variant, char_double;
  logic hsync_n_pin, dot_clk_pin, ser_clk_pin, ser_data_pin, ser_cs_n_pin;
  logic direct_mode, green_allowed, dev_direct;
  logic [15:0] last_word;
  logic [7:0] frames, dot_edges;
  cmd_req_t req;
  int fails, compares, cycles;

  dot_clock_source_control dot_clock_source_control_i (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .cmd_done(cmd_done), .cmd_refused(cmd_refused), .std_ntsc(std_ntsc),
    .osc_off(osc_off), .ext_clk_en(ext_clk_en), .slow_variant(slow_variant),
    .char_double(char_double), .hsync_n_pin(hsync_n_pin), .dot_clk_pin(dot_clk_pin),
    .ser_clk_pin(ser_clk_pin), .ser_data_pin(ser_data_pin), .ser_cs_n_pin(ser_cs_n_pin),
    .direct_mode(direct_mode), .green_allowed(green_allowed));

  osd_device_model osd_device_model_i (
    .ser_clk(ser_clk_pin), .ser_data(ser_data_pin), .ser_cs_n(ser_cs_n_pin),
    .ntsc_sel(std_ntsc), .dot_clk(dot_clk_pin), .hsync_n(hsync_n_pin),
    .last_word(last_word), .dev_direct(dev_direct), .frames(frames),
    .dot_edges(dot_edges));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs about nine hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input req_kind_t k, input logic [1:0] c, input logic [15:0] w,
                     input logic ok);
    int i;
    logic [7:0] f0;
    f0 = frames;
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{kind: k, code: c, word: w};
    @(posedge clk);
    req_valid <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && i < 60);
    check("cmd_done", {15'h0, ok}, {15'h0, cmd_done});
    check("cmd_refused", {15'h0, !ok}, {15'h0, cmd_refused});
    @(negedge clk);
    check("frames", {8'h0, f0 + {7'h0, ok}}, {8'h0, frames});
  endtask

  task automatic mode_state(input logic exp);
    check("direct_mode", {15'h0, exp}, {15'h0, direct_mode});
    check("green_allowed", {15'h0, !exp}, {15'h0, green_allowed});
    check("device direct", {15'h0, exp}, {15'h0, dev_direct});
  endtask

  task automatic hpulse(input logic slow, input logic dbl);
    int a, t, n;
    logic [7:0] e1;
    a = slow ? 10 : 4;
    t = dbl ? 8 : 4;
    slow_variant <= slow;
    char_double  <= dbl;
    repeat (100) @(posedge clk);
    hsync_n_pin <= 1'b0;
    repeat (40) @(posedge clk);
    @(negedge clk);
    e1 = dot_edges;
    check("edges low", 16'h1, {15'h0, e1 >= t + a / 2});
    check("edges high", 16'h1, {15'h0, e1 <= t + a / 2 + 3});
    repeat (20) @(negedge clk);
    check("no edge in sync", {8'h0, e1}, {8'h0, dot_edges});
    check("halted at rise", 16'h0, {15'h0, dot_clk_pin});
    @(posedge clk);
    hsync_n_pin <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dot_clk_pin !== 1'b1 && n < 40);
    check("restart late", 16'h1, {15'h0, n >= a + 3});
    check("restart bound", 16'h1, {15'h0, n <= a + 6});
  endtask

  initial begin
    rst = 1'b1; req_valid = 1'b0; req = '0; std_ntsc = 1'b1; osc_off = 1'b1;
    ext_clk_en = 1'b0; slow_variant = 1'b0; char_double = 1'b0; hsync_n_pin = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    mode_state(1'b0);
    check("cs_n idle", 16'h1, {15'h0, ser_cs_n_pin});
    cmd(REQ_MODE, 2'h3, 16'h0000, 1'b1);
    check("set word", 16'hB0FC, last_word);
    mode_state(1'b1);
    cmd(REQ_MODE, 2'h1, 16'h0000, 1'b0);
    cmd(REQ_MODE, 2'h2, 16'h0000, 1'b0);
    mode_state(1'b1);
    std_ntsc <= 1'b0;
    cmd(REQ_MODE, 2'h0, 16'h0000, 1'b0);
    mode_state(1'b1);
    std_ntsc <= 1'b1;
    cmd(REQ_MODE, 2'h0, 16'h0000, 1'b1);
    check("clear word", 16'hB0F0, last_word);
    mode_state(1'b0);
    osc_off <= 1'b0;
    cmd(REQ_MODE, 2'h3, 16'h0000, 1'b0);
    osc_off  <= 1'b1;
    std_ntsc <= 1'b0;
    cmd(REQ_MODE, 2'h3, 16'h0000, 1'b0);
    mode_state(1'b0);
    cmd(REQ_RAW, 2'h0, 16'h5A3C, 1'b1);
    check("raw word", 16'h5A3C, last_word);
    std_ntsc   <= 1'b1;
    ext_clk_en <= 1'b1;
    // The clock waits for a sync rise before starting, so prime one line.
    repeat (20) @(posedge clk);
    hsync_n_pin <= 1'b0;
    repeat (30) @(posedge clk);
    hsync_n_pin <= 1'b1;
    hpulse(1'b0, 1'b0);
    hpulse(1'b0, 1'b1);
    hpulse(1'b1, 1'b0);
    hpulse(1'b1, 1'b1);
    end_sim();
  end

endmodule

`default_nettype wire
